// ### bench/downstream_bus_model.sv
// Purpose: Far-side stand-in that raises downstream bus events on command
// Assumes: evt bits are one-cycle pulses from the bench
// Notes:   Pins idle high while their counters are zero and stay low four cycles per event
`timescale 1ns/100ps
module downstream_bus_model (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [5:0] evt,
   output logic            targetAbortSent,
   output logic            targetAbortRcvd,
   output logic            masterAbortRcvd,
   output logic            parityErrDetected,
   output logic            downstream_parity_error_n,
   output logic            downstream_system_error_n
);
   logic [2:0] perrCnt_ff;
   logic [2:0] serrCnt_ff;

   assign targetAbortSent   = evt[0];
   assign targetAbortRcvd   = evt[1];
   assign masterAbortRcvd   = evt[2];
   assign parityErrDetected = evt[3];

   // Held low long enough to pass the three-flop synchroniser
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         perrCnt_ff <= 3'h0;
         serrCnt_ff <= 3'h0;
      end else begin
         perrCnt_ff <= evt[4] ? 3'h4 : perrCnt_ff - {2'h0, |perrCnt_ff};
         serrCnt_ff <= evt[5] ? 3'h4 : serrCnt_ff - {2'h0, |serrCnt_ff};
      end
   end
   assign downstream_parity_error_n = (perrCnt_ff == 3'h0);
   assign downstream_system_error_n = (serrCnt_ff == 3'h0);
endmodule // downstream_bus_model

// ### bench/tb_bridge_bus_io_window_status_regs.sv
// Purpose: Self-checking bench for bus numbers, I/O window and downstream status
// Assumes: Register port reads answer in the cycle after the strobe
// Notes:   Events come from the far-side model; expectations are built here
`timescale 1ns/100ps
module tb_bridge_bus_io_window_status_regs;
   import bridge_cfg_pkg::*;
   logic              clk = 1'b0;
   logic              reset_n = 1'b0;
   logic [ADDR_W-1:0] regAddr = 8'h00;
   logic [31:0]       regWdata = 32'h0;
   logic              regWrite = 1'b0;
   logic              regRead = 1'b0;
   logic [31:0]       regRdata;
   logic [5:0]        evt = 6'h00;
   logic              tas, tar, mar, ped, perrN, serrN;
   logic [31:0]       ioAddr = 32'h0;
   logic              ioValid = 1'b0;
   logic              ioInWindow;
   logic [7:0]        upB, dnB, hiB, lat;
   int                errors = 0;
   int                checksDone = 0;
   int                bitPos [6] = '{27, 28, 29, 31, 24, 30};
   logic [31:0]       expSt;

   always #10 clk = ~clk;

   downstream_bus_model i_downstream_bus_model (.clk(clk), .reset_n(reset_n), .evt(evt),
      .targetAbortSent(tas), .targetAbortRcvd(tar), .masterAbortRcvd(mar),
      .parityErrDetected(ped), .downstream_parity_error_n(perrN),
      .downstream_system_error_n(serrN));

   bridge_bus_io_window_status_regs i_bridge_bus_io_window_status_regs (.clk(clk),
      .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .downstream_parity_error_n(perrN),
      .downstream_system_error_n(serrN), .targetAbortSent(tas), .targetAbortRcvd(tar),
      .masterAbortRcvd(mar), .parityErrDetected(ped), .ioAddr(ioAddr), .ioValid(ioValid),
      .ioInWindow(ioInWindow), .upstreamBus(upB), .downstreamBus(dnB),
      .highestBelowBus(hiB), .latencyTimer(lat));

   task automatic print_verdict();
      if (errors == 0 && checksDone > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(regRdata, exp);
   endtask

   task automatic win(input logic v, input logic [31:0] a, input logic exp);
      @(posedge clk);
      ioAddr <= a;
      ioValid <= v;
      @(posedge clk);
      #1 chk({31'h0, ioInWindow}, {31'h0, exp});
   endtask

   task automatic fire(input int i);
      @(posedge clk);
      evt <= 6'h01 << i;
      @(posedge clk);
      evt <= 6'h00;
      repeat (8) @(posedge clk);
   endtask

   initial begin
      #1000000;
      errors++;
      print_verdict();
   end

   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      // ---------------------------------------------------------------
      // Reset values and an unmapped place
      // ---------------------------------------------------------------
      rd(OFF_BUS_NUMBERS, 32'h0000_0000);
      rd(OFF_IO_STATUS, 32'h0220_0101);
      rd(8'h40, 32'h0000_0000);
      wr(8'h40, 32'hffff_ffff);
      // ---------------------------------------------------------------
      // Bus number fields and their outputs
      // ---------------------------------------------------------------
      wr(OFF_BUS_NUMBERS, 32'ha5c3_3c5a);
      chk({lat, hiB, dnB, upB}, 32'ha5c3_3c5a);
      rd(OFF_BUS_NUMBERS, 32'ha5c3_3c5a);
      // ---------------------------------------------------------------
      // Read-only and reserved bits ignore writes
      // ---------------------------------------------------------------
      wr(OFF_IO_STATUS, 32'h06ff_ffff);
      rd(OFF_IO_STATUS, 32'h0220_f1f1);
      // ---------------------------------------------------------------
      // I/O window edges: bottom low bits zero, top low bits all ones
      // ---------------------------------------------------------------
      wr(OFF_IO_STATUS, 32'h0000_5030);
      wr(OFF_IO_UPPER, 32'h0001_0001);
      win(1'b1, 32'h0001_3000, 1'b1);
      win(1'b1, 32'h0001_2fff, 1'b0);
      win(1'b1, 32'h0001_5fff, 1'b1);
      win(1'b1, 32'h0001_6000, 1'b0);
      win(1'b1, 32'h0002_4000, 1'b0);
      win(1'b0, 32'h0001_4000, 1'b0);
      // ---------------------------------------------------------------
      // Status flags: parity pin gated by command bit, then every event
      // ---------------------------------------------------------------
      expSt = 32'h0220_5131;
      fire(4);
      rd(OFF_IO_STATUS, expSt);
      wr(OFF_COMMAND, 32'h0000_0040);
      rd(OFF_COMMAND, 32'h0000_0040);
      for (int i = 0; i < 6; i++) begin
         fire(i);
         expSt[bitPos[i]] = 1'b1;
         rd(OFF_IO_STATUS, expSt);
      end
      wr(OFF_IO_STATUS, 32'hd900_5030);
      rd(OFF_IO_STATUS, 32'h2220_5131);
      // Clear and set in one cycle: the set must win
      @(posedge clk);
      regAddr <= OFF_IO_STATUS;
      regWdata <= 32'h2000_5030;
      regWrite <= 1'b1;
      evt <= 6'h04;
      @(posedge clk);
      regWrite <= 1'b0;
      evt <= 6'h00;
      rd(OFF_IO_STATUS, 32'h2220_5131);
      wr(OFF_IO_STATUS, 32'h2000_5030);
      rd(OFF_IO_STATUS, 32'h0220_5131);
      print_verdict();
   end
endmodule // tb_bridge_bus_io_window_status_regs

// ### src/bridge_bus_io_window_status_regs.sv
// Purpose: Bus numbers, downstream latency timer, I/O window and downstream status registers
// Assumes: Single 50 MHz clock, event inputs are synchronous one-cycle pulses except pins
// Notes:   Pin inputs pass three flops; a fall is seen when stages two and three agree
//
// Function
// R1: Read/write upstream bus number in bits 7:0, reset zero.
// R2: Read/write downstream bus number in bits 15:8, reset zero.
// R3: Read/write highest bus number below bridge in bits 23:16, reset zero.
// R4: Read/write downstream latency timer in bits 31:24, bus clocks, reset zero.
// R5: I/O bottom and top low nibbles read-only, return 1 for 32-bit I/O.
// R6: Bottom bits 7:4 give address 15:12; low twelve address bits are zero.
// R7: Top bits 15:12 give address 15:12; low twelve address bits are FFFh.
// R8: Bounds decide I/O forwarding; upper sixteen bits come from upper register.
// R9: Status bit 21 read-only one: downstream 66MHz capable.
// R10: Status bit 23 read-only zero: no fast back-to-back decoding.
// R11: Bit 24 set on downstream parity error pin while command bit 6 set.
// R12: Bits 26:25 read-only 01, medium select speed.
// R13: Bit 27 set when device as target signals target abort.
// R14: Bit 28 set when device-mastered transaction gets target abort.
// R15: Bit 29 set when device-mastered transaction gets master abort.
// R16: Bit 30 set when downstream system error pin asserts.
// R17: Bit 31 set on downstream address or data parity error.
// R18: Write one clears a flag, zero keeps it; hardware set wins.
// R19: Reserved status bits 20:16 and 22 read zero, ignore writes.
`timescale 1ns/100ps
module bridge_bus_io_window_status_regs
   import bridge_cfg_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic [ADDR_W-1:0]   regAddr,
   input  wire logic [31:0]         regWdata,
   input  wire logic                regWrite,
   input  wire logic                regRead,
   output logic      [31:0]         regRdata,
   input  wire logic                downstream_parity_error_n,
   input  wire logic                downstream_system_error_n,
   input  wire logic                targetAbortSent,
   input  wire logic                targetAbortRcvd,
   input  wire logic                masterAbortRcvd,
   input  wire logic                parityErrDetected,
   input  wire logic [31:0]         ioAddr,
   input  wire logic                ioValid,
   output logic                     ioInWindow,
   output logic [7:0]               upstreamBus,
   output logic [7:0]               downstreamBus,
   output logic [7:0]               highestBelowBus,
   output logic [7:0]               latencyTimer
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]          rdata;
      logic [7:0]           upBus;
      logic [7:0]           dnBus;
      logic [7:0]           hiBus;
      logic [7:0]           latency;
      logic [3:0]           ioBot;
      logic [3:0]           ioTop;
      logic [15:0]          ioBotUpper;
      logic [15:0]          ioTopUpper;
      logic                 perrResp;
      logic [NUM_FLAGS-1:0] flags;
      logic [2:0]           perrSync;
      logic [2:0]           serrSync;
      logic                 inWindow;
   } state_t;

   state_t state_ff;
   state_t nxt_state;

   localparam state_t RESET_STATE = '0;

   // Flag index order within flags
   localparam int F_PAR  = 0;
   localparam int F_STA  = 1;
   localparam int F_RTA  = 2;
   localparam int F_RMA  = 3;
   localparam int F_SERR = 4;
   localparam int F_DPE  = 5;

   function automatic logic [NUM_FLAGS-1:0] flagsFromWord(input logic [31:0] w);
      flagsFromWord = {w[ST_PARITY_DET], w[ST_SYS_ERR], w[ST_RCV_MABORT],
                       w[ST_RCV_TABORT], w[ST_SIG_TABORT], w[ST_PARITY_RPT]};
   endfunction

   function automatic logic [31:0] statusWord(input state_t s);
      logic [31:0] w;
      w = ZERO_WORD;                                         // R19
      w[IO_BOT_CAP_LSB +: 4] = IO_CAP_32BIT;                 // R5
      w[IO_BOT_LSB +: 4]     = s.ioBot;                      // R6
      w[IO_TOP_CAP_LSB +: 4] = IO_CAP_32BIT;                 // R5
      w[IO_TOP_LSB +: 4]     = s.ioTop;                      // R7
      w[ST_66MHZ]            = CAP_66MHZ;                    // R9
      w[ST_FB2B]             = CAP_FB2B;                     // R10
      w[ST_SEL_LSB +: 2]     = SEL_SPEED_MEDIUM;             // R12
      w[ST_PARITY_RPT]       = s.flags[F_PAR];
      w[ST_SIG_TABORT]       = s.flags[F_STA];
      w[ST_RCV_TABORT]       = s.flags[F_RTA];
      w[ST_RCV_MABORT]       = s.flags[F_RMA];
      w[ST_SYS_ERR]          = s.flags[F_SERR];
      w[ST_PARITY_DET]       = s.flags[F_DPE];
      statusWord = w;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [NUM_FLAGS-1:0] setEv;
   logic [NUM_FLAGS-1:0] clrEv;
   logic [31:0]          winBot;
   logic [31:0]          winTop;
   logic                 perrPin;
   logic                 serrPin;

   always_comb begin
      nxt_state = state_ff;
      nxt_state.perrSync = {state_ff.perrSync[1:0], downstream_parity_error_n};
      nxt_state.serrSync = {state_ff.serrSync[1:0], downstream_system_error_n};
      // Pins are active low; second and third stages must agree on low
      perrPin = ~state_ff.perrSync[1] & ~state_ff.perrSync[2];
      serrPin = ~state_ff.serrSync[1] & ~state_ff.serrSync[2];

      setEv = '0;
      setEv[F_PAR]  = perrPin & state_ff.perrResp;           // R11
      setEv[F_STA]  = targetAbortSent;                       // R13
      setEv[F_RTA]  = targetAbortRcvd;                       // R14
      setEv[F_RMA]  = masterAbortRcvd;                       // R15
      setEv[F_SERR] = serrPin;                               // R16
      setEv[F_DPE]  = parityErrDetected;                     // R17

      clrEv = '0;
      if (regWrite && regAddr == OFF_IO_STATUS) begin
         clrEv = flagsFromWord(regWdata);
      end
      // Set wins over a same-cycle clear
      nxt_state.flags = (state_ff.flags & ~clrEv) | setEv;   // R18

      if (regWrite) begin
         case (regAddr)
            OFF_BUS_NUMBERS: begin
               nxt_state.upBus   = regWdata[UPBUS_LSB +: 8];   // R1
               nxt_state.dnBus   = regWdata[DNBUS_LSB +: 8];   // R2
               nxt_state.hiBus   = regWdata[HIBUS_LSB +: 8];   // R3
               nxt_state.latency = regWdata[LATENCY_LSB +: 8]; // R4
            end
            OFF_IO_STATUS: begin
               nxt_state.ioBot = regWdata[IO_BOT_LSB +: 4];    // R6
               nxt_state.ioTop = regWdata[IO_TOP_LSB +: 4];    // R7
            end
            OFF_IO_UPPER: begin
               nxt_state.ioBotUpper = regWdata[15:0];
               nxt_state.ioTopUpper = regWdata[31:16];
            end
            OFF_COMMAND: begin
               nxt_state.perrResp = regWdata[CMD_PERR_RESP];
            end
            default: begin
            end
         endcase
      end

      nxt_state.rdata = ZERO_WORD;
      if (regRead) begin
         case (regAddr)
            OFF_BUS_NUMBERS: nxt_state.rdata = {state_ff.latency, state_ff.hiBus,
                                                 state_ff.dnBus, state_ff.upBus};
            OFF_IO_STATUS:   nxt_state.rdata = statusWord(state_ff);
            OFF_IO_UPPER:    nxt_state.rdata = {state_ff.ioTopUpper, state_ff.ioBotUpper};
            OFF_COMMAND: begin
               nxt_state.rdata                = ZERO_WORD;
               nxt_state.rdata[CMD_PERR_RESP] = state_ff.perrResp;
            end
            default:         nxt_state.rdata = ZERO_WORD;
         endcase
      end

      // Window check against registered bounds; result one cycle later
      winBot = {state_ff.ioBotUpper, state_ff.ioBot, IO_BOT_LOW};  // R6
      winTop = {state_ff.ioTopUpper, state_ff.ioTop, IO_TOP_LOW};  // R7
      nxt_state.inWindow = ioValid && ioAddr >= winBot && ioAddr <= winTop; // R8
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= RESET_STATE;
         state_ff.perrSync <= 3'h7;
         state_ff.serrSync <= 3'h7;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign regRdata        = state_ff.rdata;
   assign ioInWindow      = state_ff.inWindow;
   assign upstreamBus     = state_ff.upBus;
   assign downstreamBus   = state_ff.dnBus;
   assign highestBelowBus = state_ff.hiBus;
   assign latencyTimer    = state_ff.latency;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_busnum_write: assert property (@(posedge clk) disable iff (!reset_n) // R1
      regWrite && regAddr == OFF_BUS_NUMBERS |=> upstreamBus == $past(regWdata[7:0])
         && downstreamBus == $past(regWdata[15:8])) else $error("bus number write lost");
   a_highbus_write: assert property (@(posedge clk) disable iff (!reset_n) // R3
      regWrite && regAddr == OFF_BUS_NUMBERS |=> highestBelowBus == $past(regWdata[23:16]))
      else $error("highest bus write lost");
   a_latency_write: assert property (@(posedge clk) disable iff (!reset_n) // R4
      regWrite && regAddr == OFF_BUS_NUMBERS |=> latencyTimer == $past(regWdata[31:24]))
      else $error("latency timer write lost");
   a_status_consts: assert property (@(posedge clk) disable iff (!reset_n) // R12
      regRead && regAddr == OFF_IO_STATUS |=> regRdata[26:25] == 2'h1
         && regRdata[23:21] == 3'h1 && regRdata[20:16] == 5'h00
         && regRdata[3:0] == 4'h1 && regRdata[11:8] == 4'h1)
      else $error("status constant bits wrong");
   a_sysErr_set: assert property (@(posedge clk) disable iff (!reset_n) // R16
      $fell(downstream_system_error_n) ##1 !downstream_system_error_n[*2]
         |=> ##1 state_ff.flags[F_SERR]) else $error("system error flag not set");
   a_abort_set: assert property (@(posedge clk) disable iff (!reset_n) // R15
      masterAbortRcvd |=> state_ff.flags[F_RMA]) else $error("master abort flag not set");
   a_clear_one: assert property (@(posedge clk) disable iff (!reset_n) // R18
      regWrite && regAddr == OFF_IO_STATUS && regWdata[ST_SIG_TABORT] && !targetAbortSent
         |=> !state_ff.flags[F_STA]) else $error("write one did not clear");
   a_keep_zero: assert property (@(posedge clk) disable iff (!reset_n) // R18
      state_ff.flags[F_DPE] && !(regWrite && regAddr == OFF_IO_STATUS
         && regWdata[ST_PARITY_DET]) |=> state_ff.flags[F_DPE])
      else $error("flag lost without clear");
   a_window_low: assert property (@(posedge clk) disable iff (!reset_n) // R8
      ioValid && ioAddr == {state_ff.ioBotUpper, state_ff.ioBot, 12'h000}
         && {state_ff.ioBotUpper, state_ff.ioBot} <= {state_ff.ioTopUpper, state_ff.ioTop}
         |=> ioInWindow)
      else $error("bottom of window not forwarded");

endmodule // bridge_bus_io_window_status_regs

// ### src/bridge_cfg_pkg.sv
// Purpose: Shared constants for the bridge bus-number, I/O window and downstream status registers
// Assumes: 32-bit register port, word offsets as byte addresses
// Notes:   Field positions, read-only constant values and register offsets are defined here
package bridge_cfg_pkg;
   localparam int          ADDR_W           = 8;
   localparam logic [7:0]  OFF_BUS_NUMBERS  = 8'h18;
   localparam logic [7:0]  OFF_IO_STATUS    = 8'h1c;
   localparam logic [7:0]  OFF_IO_UPPER     = 8'h30;
   localparam logic [7:0]  OFF_COMMAND      = 8'h04;

   localparam int          UPBUS_LSB        = 0;
   localparam int          DNBUS_LSB        = 8;
   localparam int          HIBUS_LSB        = 16;
   localparam int          LATENCY_LSB      = 24;

   localparam int          IO_BOT_CAP_LSB   = 0;
   localparam int          IO_BOT_LSB       = 4;
   localparam int          IO_TOP_CAP_LSB   = 8;
   localparam int          IO_TOP_LSB       = 12;
   localparam logic [3:0]  IO_CAP_32BIT     = 4'h1;
   localparam logic [11:0] IO_BOT_LOW       = 12'h000;
   localparam logic [11:0] IO_TOP_LOW       = 12'hfff;

   localparam int          ST_66MHZ         = 21;
   localparam int          ST_FB2B          = 23;
   localparam int          ST_PARITY_RPT    = 24;
   localparam int          ST_SEL_LSB       = 25;
   localparam int          ST_SIG_TABORT    = 27;
   localparam int          ST_RCV_TABORT    = 28;
   localparam int          ST_RCV_MABORT    = 29;
   localparam int          ST_SYS_ERR       = 30;
   localparam int          ST_PARITY_DET    = 31;
   localparam logic [1:0]  SEL_SPEED_MEDIUM = 2'h1;
   localparam logic        CAP_66MHZ        = 1'b1;
   localparam logic        CAP_FB2B         = 1'b0;

   localparam int          CMD_PERR_RESP    = 6;
   localparam int          NUM_FLAGS        = 6;
   localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
endpackage : bridge_cfg_pkg
